// ===== core/acpm_regs.svh
// Parameter indices, reset values, bit positions and limits of the channel monitor
`ifndef ACPM_REGS_SVH
`define ACPM_REGS_SVH

`define ACPM_IDX_DIAG_EN 8'h40
`define ACPM_IDX_LOWER 8'h41
`define ACPM_IDX_UPPER 8'h42
`define ACPM_IDX_AVG_LEN 8'h43
`define ACPM_IDX_FUNC 8'h44

`define ACPM_RST_DIAG_EN 16'h0000
`define ACPM_RST_LOWER 16'h8000
`define ACPM_RST_UPPER 16'h7fff
`define ACPM_RST_AVG_LEN 8'h00
`define ACPM_FUNC_OUT_DEF 8'h06
`define ACPM_FUNC_IN_DEF 8'h01

`define ACPM_FUNC_OUT_U_UNI 8'h06
`define ACPM_FUNC_OUT_U_BI 8'h07
`define ACPM_FUNC_OUT_I_0_20 8'h08
`define ACPM_FUNC_OUT_I_4_20 8'h09
`define ACPM_FUNC_IN_U_UNI 8'h01
`define ACPM_FUNC_IN_U_BI 8'h02
`define ACPM_FUNC_IN_I_0_20 8'h03
`define ACPM_FUNC_IN_I_4_20 8'h04

`define ACPM_AVG_MAX 8'h40

`define ACPM_BIT_BELOW_MIN 1
`define ACPM_BIT_ABOVE_MAX 2
`define ACPM_BIT_OVERTEMP 3
`define ACPM_BIT_SUPPLY_HI 4
`define ACPM_BIT_SUPPLY_LO 5
`define ACPM_BIT_VOUT_LOW 6
`define ACPM_BIT_VOUT_HIGH 7
`define ACPM_BIT_CABLE_BRK 10
`define ACPM_BIT_SENS_OVC 11
`define ACPM_BIT_UNDERDRV 14
`define ACPM_BIT_OVERDRV 15

`define ACPM_PD_FULL_POS 16'sh6c00
`define ACPM_PD_FULL_NEG -16'sh6c00
`define ACPM_PD_ZERO 16'sh0000

`define ACPM_CODE_BELOW_MIN 16'h1802
`define ACPM_CODE_ABOVE_MAX 16'h1803

`endif

// ===== core/acpm_pkg.sv
// Types shared by the channel monitor modules
package acpm_pkg;
    typedef enum logic [1:0] {
        ACPM_LAY_U_UNI,
        ACPM_LAY_U_BI,
        ACPM_LAY_I_0_20,
        ACPM_LAY_I_4_20
    } acpm_layout_t;

    typedef enum logic {
        ACPM_DIV_IDLE,
        ACPM_DIV_RUN
    } acpm_div_state_t;
endpackage : acpm_pkg

// ===== core/acpm_avg.sv
// Moving-average filter over up to 64 samples with serial divider
`timescale 1ns/1ps
`default_nettype none
`include "acpm_regs.svh"

module acpm_avg
    import acpm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic signed [15:0] sample_i,
    input wire logic sample_valid,
    input wire logic [7:0] window,
    output logic signed [15:0] avg_q,
    output logic avg_valid_q
);
    logic signed [15:0] ring_q [0:63];
    logic [5:0] ptr_q;
    logic [6:0] fill_q;
    logic [6:0] fill_d;
    logic [7:0] win_q;
    logic signed [22:0] sum_q;
    logic signed [22:0] sum_d;
    logic signed [15:0] oldest;
    acpm_div_state_t div_q;
    logic [22:0] quo_q;
    logic [7:0] rem_q;
    logic [7:0] rem_n;
    logic [22:0] quo_n;
    logic [7:0] dvs_q;
    logic neg_q;
    logic [4:0] cnt_q;
    logic take;

    // Samples arriving mid-division are dropped; an IO-Link cycle is far longer
    assign take = sample_valid && (div_q == ACPM_DIV_IDLE);
    assign oldest = ring_q[ptr_q - win_q[5:0]];
    assign fill_d = (fill_q == win_q[6:0]) ? fill_q : fill_q + 7'd1;
    assign sum_d = sum_q + 23'(sample_i)
                   - ((fill_q == win_q[6:0]) ? 23'(oldest) : 23'sd0);
    assign rem_n = {rem_q[6:0], quo_q[22]};
    // Final quotient bit lands in the same edge as the result
    assign quo_n = {quo_q[21:0], rem_n >= dvs_q};

    always_ff @(posedge clk_sys) begin
        if (take) begin
            ring_q[ptr_q] <= sample_i;
        end
    end

    // Window change restarts the history so no stale samples mix in
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ptr_q <= 6'h00;
            fill_q <= 7'h00;
            sum_q <= 23'sh000000;
            win_q <= `ACPM_RST_AVG_LEN;
        end else if (window != win_q) begin
            ptr_q <= 6'h00;
            fill_q <= 7'h00;
            sum_q <= 23'sh000000;
            win_q <= window;
        end else if (take && win_q != 8'h00) begin
            ptr_q <= ptr_q + 6'h01;
            fill_q <= fill_d;
            sum_q <= sum_d;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            div_q <= ACPM_DIV_IDLE;
            quo_q <= 23'h000000;
            rem_q <= 8'h00;
            dvs_q <= 8'h01;
            neg_q <= 1'b0;
            cnt_q <= 5'h00;
            avg_q <= 16'sh0000;
            avg_valid_q <= 1'b0;
        end else begin
            avg_valid_q <= 1'b0;
            case (div_q)
                ACPM_DIV_IDLE: begin
                    if (take && window == win_q && win_q == 8'h00) begin
                        avg_q <= sample_i;
                        avg_valid_q <= 1'b1;
                    end else if (take && window == win_q) begin
                        neg_q <= sum_d[22];
                        quo_q <= sum_d[22] ? 23'(-sum_d) : 23'(sum_d);
                        rem_q <= 8'h00;
                        dvs_q <= {1'b0, fill_d};
                        cnt_q <= 5'd22;
                        div_q <= ACPM_DIV_RUN;
                    end
                end
                ACPM_DIV_RUN: begin
                    if (rem_n >= dvs_q) begin
                        rem_q <= rem_n - dvs_q;
                        quo_q <= {quo_q[21:0], 1'b1};
                    end else begin
                        rem_q <= rem_n;
                        quo_q <= {quo_q[21:0], 1'b0};
                    end
                    cnt_q <= cnt_q - 5'd1;
                    if (cnt_q == 5'd0) begin
                        avg_q <= neg_q ? -quo_n[15:0] : quo_n[15:0];
                        avg_valid_q <= 1'b1;
                        div_q <= ACPM_DIV_IDLE;
                    end
                end
                default: div_q <= ACPM_DIV_IDLE;
            endcase
        end
    end
endmodule : acpm_avg
`default_nettype wire

// ===== core/acpm_top.sv
// Parameter store and diagnostic monitor for one analog converter channel
//
// Overview of operation
// - Event raised only while its enable bit set
// - Bit 1 below-min, bit 2 above-max enables
// - Bit 3 enables overtemperature above 85 C
// - Bits 4/5 enable supply over/under voltage
// - Current outputs: bit 10 break; bit 11 overcurrent in all functions
// - Unipolar: underdrive below 0, overdrive above 27648
// - Bipolar voltage: limits are -27648 and 27648
// - Voltage outputs: bits 6/7 output below/above setpoint
// - Bit layout follows active channel function
// - Output multi accepts codes 0x06 to 0x09
// - Input multi accepts codes 0x01 to 0x04
// - Multi variant: illegal function code raises error alert
// - Multi variant write changes active function
// - Fixed variant accepts write, keeps value
// - Below lower threshold raises minimum event
// - Above upper threshold raises maximum event
// - Output variant compares master output data
// - Input variant compares data sent upstream
// - Moving average counted in IO-Link cycles
// - Window 0 bypasses, 1..64 averages samples
// - Window above 64 reports an error
// - Threshold events coded 0x1802 and 0x1803
`timescale 1ns/1ps
`default_nettype none
`include "acpm_regs.svh"

module acpm_top
    import acpm_pkg::*;
#(
    parameter bit IS_OUTPUT = 1'b1,
    parameter bit IS_MULTI = 1'b1,
    parameter logic [7:0] FIXED_FUNC = `ACPM_FUNC_OUT_DEF
)
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic param_wr,
    input wire logic param_rd,
    input wire logic [7:0] param_idx,
    input wire logic [15:0] param_wdata,
    output logic [15:0] param_rdata_q,
    output logic param_ack_q,
    output logic param_err_q,
    input wire logic cycle_strobe,
    input wire logic signed [15:0] pd_out_word,
    input wire logic signed [15:0] meas_word,
    output logic signed [15:0] filtered_word_q,
    output logic filtered_valid_q,
    input wire logic temp_over_pin,
    input wire logic supply_high_pin,
    input wire logic supply_low_pin,
    input wire logic cable_break_pin,
    input wire logic sensor_ovc_pin,
    input wire logic vout_low_pin,
    input wire logic vout_high_pin,
    output logic [15:0] diag_active_q,
    output logic func_error_q,
    output logic avg_error_q,
    output logic evt_valid_q,
    output logic [15:0] evt_code_q,
    output logic evt_appear_q
);
    localparam logic [7:0] FUNC_DEF = IS_OUTPUT ? `ACPM_FUNC_OUT_DEF : `ACPM_FUNC_IN_DEF;

    logic [15:0] diag_en_q;
    logic signed [15:0] lower_q;
    logic signed [15:0] upper_q;
    logic [7:0] avg_len_q;
    logic [7:0] func_q;
    logic [6:0] pins_meta_q;
    logic [6:0] pins_q;
    logic wr_diag;
    logic wr_lower;
    logic wr_upper;
    logic wr_avg;
    logic wr_func;
    logic idx_known;
    logic func_code_ok;
    logic avg_len_ok;
    acpm_layout_t layout;
    logic [15:0] layout_mask;
    logic [15:0] raw_cond;
    logic [15:0] diag_d;
    logic signed [15:0] monitored_q;
    logic signed [15:0] filt_in;
    logic signed [15:0] avg_word;
    logic avg_valid;
    logic [15:0] rdata_d;
    logic max_rep_q;
    logic max_seen_q;
    logic evt_pend_max;

    // Parameter access decode
    assign wr_diag = param_wr && param_idx == `ACPM_IDX_DIAG_EN;
    assign wr_lower = param_wr && param_idx == `ACPM_IDX_LOWER;
    assign wr_upper = param_wr && param_idx == `ACPM_IDX_UPPER;
    assign wr_avg = param_wr && param_idx == `ACPM_IDX_AVG_LEN;
    assign wr_func = param_wr && param_idx == `ACPM_IDX_FUNC;
    assign idx_known = param_idx inside {`ACPM_IDX_DIAG_EN, `ACPM_IDX_LOWER,
                                         `ACPM_IDX_UPPER, `ACPM_IDX_AVG_LEN,
                                         `ACPM_IDX_FUNC};

    always_comb begin
        if (IS_OUTPUT) begin
            func_code_ok = param_wdata[7:0] >= `ACPM_FUNC_OUT_U_UNI
                           && param_wdata[7:0] <= `ACPM_FUNC_OUT_I_4_20;
        end else begin
            func_code_ok = param_wdata[7:0] >= `ACPM_FUNC_IN_U_UNI
                           && param_wdata[7:0] <= `ACPM_FUNC_IN_I_4_20;
        end
    end

    assign avg_len_ok = param_wdata[15:8] == 8'h00 && param_wdata[7:0] <= `ACPM_AVG_MAX;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            diag_en_q <= `ACPM_RST_DIAG_EN;
        end else if (wr_diag) begin
            diag_en_q <= param_wdata;
        end
    end

    // Stored as written, scaling is master's
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            lower_q <= `ACPM_RST_LOWER;
        end else if (wr_lower) begin
            lower_q <= param_wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            upper_q <= `ACPM_RST_UPPER;
        end else if (wr_upper) begin
            upper_q <= param_wdata;
        end
    end

    // Illegal window is not adopted so the filter keeps running
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            avg_len_q <= `ACPM_RST_AVG_LEN;
        end else if (wr_avg && avg_len_ok) begin
            avg_len_q <= param_wdata[7:0];
        end
    end

    // Error stands until a legal window is written
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            avg_error_q <= 1'b0;
        end else if (wr_avg) begin
            avg_error_q <= !avg_len_ok;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            func_q <= IS_MULTI ? FUNC_DEF : FIXED_FUNC;
        end else if (IS_MULTI && wr_func && func_code_ok && param_wdata[15:8] == 8'h00) begin
            func_q <= param_wdata[7:0];
        end
    end

    // Alert until a legal code is written
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            func_error_q <= 1'b0;
        end else if (IS_MULTI && wr_func) begin
            func_error_q <= !(func_code_ok && param_wdata[15:8] == 8'h00);
        end
    end

    always_comb begin
        case (param_idx)
            `ACPM_IDX_DIAG_EN: rdata_d = diag_en_q;
            `ACPM_IDX_LOWER: rdata_d = lower_q;
            `ACPM_IDX_UPPER: rdata_d = upper_q;
            `ACPM_IDX_AVG_LEN: rdata_d = {8'h00, avg_len_q};
            `ACPM_IDX_FUNC: rdata_d = {8'h00, func_q};
            default: rdata_d = 16'h0000;
        endcase
    end

    // Answer one cycle after the request; unknown index flagged
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            param_ack_q <= 1'b0;
            param_err_q <= 1'b0;
            param_rdata_q <= 16'h0000;
        end else begin
            param_ack_q <= param_wr || param_rd;
            param_err_q <= (param_wr || param_rd) && (!idx_known
                           || (wr_avg && !avg_len_ok)
                           || (wr_func && IS_MULTI
                               && !(func_code_ok && param_wdata[15:8] == 8'h00)));
            if (param_rd) begin
                param_rdata_q <= rdata_d;
            end
        end
    end

    // Front-end status pins cross in through two flops
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pins_meta_q <= 7'h00;
            pins_q <= 7'h00;
        end else begin
            pins_meta_q <= {vout_high_pin, vout_low_pin, sensor_ovc_pin, cable_break_pin,
                            supply_low_pin, supply_high_pin, temp_over_pin};
            pins_q <= pins_meta_q;
        end
    end

    assign filt_in = IS_OUTPUT ? pd_out_word : meas_word;

    acpm_avg u_avg (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .sample_i(filt_in),
        .sample_valid(cycle_strobe),
        .window(avg_len_q),
        .avg_q(avg_word),
        .avg_valid_q(avg_valid)
    );

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            filtered_word_q <= 16'sh0000;
            filtered_valid_q <= 1'b0;
        end else begin
            filtered_valid_q <= avg_valid;
            if (avg_valid) begin
                filtered_word_q <= avg_word;
            end
        end
    end

    // Input variant watches filtered upstream data
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            monitored_q <= 16'sh0000;
        end else if (IS_OUTPUT && cycle_strobe) begin
            monitored_q <= pd_out_word;
        end else if (!IS_OUTPUT && avg_valid) begin
            monitored_q <= avg_word;
        end
    end

    always_comb begin
        case (func_q)
            `ACPM_FUNC_OUT_U_UNI, `ACPM_FUNC_IN_U_UNI: layout = ACPM_LAY_U_UNI;
            `ACPM_FUNC_OUT_U_BI, `ACPM_FUNC_IN_U_BI: layout = ACPM_LAY_U_BI;
            `ACPM_FUNC_OUT_I_0_20, `ACPM_FUNC_IN_I_0_20: layout = ACPM_LAY_I_0_20;
            `ACPM_FUNC_OUT_I_4_20, `ACPM_FUNC_IN_I_4_20: layout = ACPM_LAY_I_4_20;
            default: layout = ACPM_LAY_U_UNI;
        endcase
    end

    always_comb begin
        layout_mask = 16'h0000;
        layout_mask[`ACPM_BIT_BELOW_MIN] = 1'b1;
        layout_mask[`ACPM_BIT_ABOVE_MAX] = 1'b1;
        layout_mask[`ACPM_BIT_OVERTEMP] = 1'b1;
        layout_mask[`ACPM_BIT_SUPPLY_HI] = 1'b1;
        layout_mask[`ACPM_BIT_SUPPLY_LO] = 1'b1;
        layout_mask[`ACPM_BIT_SENS_OVC] = 1'b1;
        layout_mask[`ACPM_BIT_UNDERDRV] = IS_OUTPUT;
        layout_mask[`ACPM_BIT_OVERDRV] = IS_OUTPUT;
        case (layout)
            ACPM_LAY_U_UNI, ACPM_LAY_U_BI: begin
                layout_mask[`ACPM_BIT_VOUT_LOW] = IS_OUTPUT;
                layout_mask[`ACPM_BIT_VOUT_HIGH] = IS_OUTPUT;
            end
            ACPM_LAY_I_0_20, ACPM_LAY_I_4_20: begin
                layout_mask[`ACPM_BIT_CABLE_BRK] = IS_OUTPUT;
            end
            default: begin
                layout_mask[`ACPM_BIT_CABLE_BRK] = 1'b0;
            end
        endcase
    end

    always_comb begin
        raw_cond = 16'h0000;
        raw_cond[`ACPM_BIT_BELOW_MIN] = monitored_q < lower_q;
        raw_cond[`ACPM_BIT_ABOVE_MAX] = monitored_q > upper_q;
        raw_cond[`ACPM_BIT_OVERTEMP] = pins_q[0];
        raw_cond[`ACPM_BIT_SUPPLY_HI] = pins_q[1];
        raw_cond[`ACPM_BIT_SUPPLY_LO] = pins_q[2];
        raw_cond[`ACPM_BIT_CABLE_BRK] = pins_q[3];
        raw_cond[`ACPM_BIT_SENS_OVC] = pins_q[4];
        raw_cond[`ACPM_BIT_VOUT_LOW] = pins_q[5];
        raw_cond[`ACPM_BIT_VOUT_HIGH] = pins_q[6];
        if (layout == ACPM_LAY_U_BI) begin
            raw_cond[`ACPM_BIT_UNDERDRV] = monitored_q < `ACPM_PD_FULL_NEG;
        end else begin
            raw_cond[`ACPM_BIT_UNDERDRV] = monitored_q < `ACPM_PD_ZERO;
        end
        raw_cond[`ACPM_BIT_OVERDRV] = monitored_q > `ACPM_PD_FULL_POS;
    end

    // Threshold enables at bits 1 and 2
    assign diag_d = raw_cond & diag_en_q & layout_mask;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            diag_active_q <= 16'h0000;
        end else begin
            diag_active_q <= diag_d;
        end
    end

    // Appearing/disappearing threshold messages
    // Minimum wins when both change in one cycle; maximum reports next cycle
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            evt_valid_q <= 1'b0;
            evt_code_q <= 16'h0000;
            evt_appear_q <= 1'b0;
        end else if (diag_d[`ACPM_BIT_BELOW_MIN] != diag_active_q[`ACPM_BIT_BELOW_MIN]) begin
            evt_valid_q <= 1'b1;
            evt_code_q <= `ACPM_CODE_BELOW_MIN;
            evt_appear_q <= diag_d[`ACPM_BIT_BELOW_MIN];
        end else if (evt_pend_max) begin
            evt_valid_q <= 1'b1;
            evt_code_q <= `ACPM_CODE_ABOVE_MAX;
            evt_appear_q <= max_seen_q;
        end else begin
            evt_valid_q <= 1'b0;
        end
    end

    // Last maximum state told to the master
    assign evt_pend_max = max_seen_q != max_rep_q;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            max_seen_q <= 1'b0;
        end else begin
            max_seen_q <= diag_d[`ACPM_BIT_ABOVE_MAX];
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            max_rep_q <= 1'b0;
        end else if (evt_pend_max
                     && diag_d[`ACPM_BIT_BELOW_MIN] == diag_active_q[`ACPM_BIT_BELOW_MIN]) begin
            max_rep_q <= max_seen_q;
        end
    end
endmodule : acpm_top
`default_nettype wire

// ===== sim/acpm_monitor.sv
// Checker for the parameter, filter and event ports of the channel monitor
`timescale 1ns/1ps
`default_nettype none
module acpm_monitor (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic param_wr,
    input wire logic param_rd,
    input wire logic [7:0] param_idx,
    input wire logic [15:0] param_wdata,
    input wire logic param_ack_q,
    input wire logic param_err_q,
    input wire logic cycle_strobe,
    input wire logic filtered_valid_q,
    input wire logic [15:0] diag_active_q,
    input wire logic func_error_q,
    input wire logic avg_error_q,
    input wire logic evt_valid_q,
    input wire logic [15:0] evt_code_q,
    input wire logic evt_appear_q
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sequence s_req; param_wr || param_rd; endsequence
    sequence s_fok; param_wr && param_idx == 8'h44 && param_wdata inside {[6:9]}; endsequence
    sequence s_fbad; param_wr && param_idx == 8'h44 && !(param_wdata inside {[6:9]}); endsequence
    sequence s_wbad; param_wr && param_idx == 8'h43 && param_wdata > 16'h0040; endsequence
    property p_ack; s_req |=> param_ack_q; endproperty
    a_ack: assert property (p_ack) else $error("request not answered");
    property p_fok; s_fok |=> !param_err_q && !func_error_q; endproperty
    a_fok: assert property (p_fok) else $error("legal code refused");
    property p_fbad; s_fbad |=> param_err_q && func_error_q; endproperty
    a_fbad: assert property (p_fbad) else $error("illegal code taken");
    property p_wbad; s_wbad |=> param_err_q && avg_error_q; endproperty
    a_wbad: assert property (p_wbad) else $error("long window taken");
    property p_filt; cycle_strobe |-> ##[2:26] filtered_valid_q; endproperty
    a_filt: assert property (p_filt) else $error("no filter result");
    property p_resv; (diag_active_q & 16'h3301) == 16'h0000; endproperty
    a_resv: assert property (p_resv) else $error("reserved bit active");
    property p_code; evt_valid_q |-> evt_code_q inside {16'h1802, 16'h1803}; endproperty
    a_code: assert property (p_code) else $error("bad event code");
    property p_min;
        evt_valid_q && evt_code_q == 16'h1802 |->
            evt_appear_q == diag_active_q[1] && $changed(diag_active_q[1]);
    endproperty
    a_min: assert property (p_min) else $error("minimum event mismatch");
    property p_max;
        evt_valid_q && evt_code_q == 16'h1803 |-> evt_appear_q == $past(diag_active_q[2]);
    endproperty
    a_max: assert property (p_max) else $error("maximum event mismatch");
endmodule : acpm_monitor
bind acpm_top acpm_monitor u_mon (.clk_sys, .rstn, .param_wr, .param_rd, .param_idx,
    .param_wdata, .param_ack_q, .param_err_q, .cycle_strobe, .filtered_valid_q,
    .diag_active_q, .func_error_q, .avg_error_q, .evt_valid_q, .evt_code_q, .evt_appear_q);
`default_nettype wire

// ===== sim/acpm_master_model.sv
// Master side model: parameter requests and process data cycles
`timescale 1ns/1ps
`default_nettype none
module acpm_master_model (
    input wire logic clk_sys,
    input wire logic param_ack_q,
    input wire logic param_err_q,
    input wire logic [15:0] param_rdata_q,
    output logic param_wr = 1'b0,
    output logic param_rd = 1'b0,
    output logic [7:0] param_idx = 8'h00,
    output logic [15:0] param_wdata = 16'h0000,
    output logic cycle_strobe = 1'b0,
    output logic signed [15:0] pd_out_word = 16'sh0000
);
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [15:0] d,
                        output logic [15:0] rd, output logic err, output logic ok);
        int n;
        @(posedge clk_sys);
        param_wr <= wr;
        param_rd <= !wr;
        param_idx <= idx;
        param_wdata <= d;
        @(posedge clk_sys);
        param_wr <= 1'b0;
        param_rd <= 1'b0;
        // Released lines must not keep the last value
        param_idx <= ~idx;
        param_wdata <= ~d;
        for (n = 0; n < 4 && param_ack_q !== 1'b1; n++) begin
            @(posedge clk_sys);
        end
        rd = param_rdata_q;
        err = param_err_q;
        ok = (n < 4);
    endtask : xfer
    task automatic cycle(input logic signed [15:0] pd);
        @(posedge clk_sys);
        cycle_strobe <= 1'b1;
        pd_out_word <= pd;
        @(posedge clk_sys);
        cycle_strobe <= 1'b0;
        pd_out_word <= ~pd;
    endtask : cycle
endmodule : acpm_master_model
`default_nettype wire

// ===== sim/acpm_top_tb.sv
// Self-checking bench for the channel monitor
`timescale 1ns/1ps
`default_nettype none
module acpm_top_tb;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic param_wr, param_rd, param_ack_q, param_err_q, cycle_strobe, filtered_valid_q;
    logic func_error_q, avg_error_q, evt_valid_q, evt_appear_q, er, ok;
    logic [7:0] param_idx;
    logic [15:0] param_wdata, param_rdata_q, diag_active_q, evt_code_q, rd;
    logic signed [15:0] pd_out_word, filtered_word_q;
    logic signed [15:0] meas_word = 16'sh0000;
    logic [6:0] pins = 7'h00;
    logic [31:0] seed = 32'h841e;
    int fail_count = 0;
    int total_checks = 0;
    int rst_val [5] = '{0, 'h8000, 'h7fff, 0, 6};
    int bnd [8] = '{-27649, -27648, -1, 0, 27648, 27649, -1001, 1001};
    int wins [4] = '{0, 1, 3, 64};

    acpm_top dut (.clk_sys, .rstn, .param_wr, .param_rd, .param_idx, .param_wdata,
        .param_rdata_q, .param_ack_q, .param_err_q, .cycle_strobe, .pd_out_word,
        .meas_word, .filtered_word_q, .filtered_valid_q, .temp_over_pin(pins[0]),
        .supply_high_pin(pins[1]), .supply_low_pin(pins[2]), .cable_break_pin(pins[3]),
        .sensor_ovc_pin(pins[4]), .vout_low_pin(pins[5]), .vout_high_pin(pins[6]),
        .diag_active_q, .func_error_q, .avg_error_q, .evt_valid_q, .evt_code_q, .evt_appear_q);
    acpm_master_model m (.clk_sys, .param_ack_q, .param_err_q, .param_rdata_q, .param_wr,
        .param_rd, .param_idx, .param_wdata, .cycle_strobe, .pd_out_word);

    initial begin
        forever #25 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic logic [15:0] exp_diag(logic [7:0] f, logic [15:0] en, int pd);
        logic [15:0] c;
        c = 16'h0000;
        c[1] = pd < -1000;
        c[2] = pd > 1000;
        c[5:3] = pins[2:0];
        c[6] = pins[5] && f < 8'h08;
        c[7] = pins[6] && f < 8'h08;
        c[10] = pins[3] && f > 8'h07;
        c[11] = pins[4];
        c[14] = (f == 8'h07) ? pd < -27648 : pd < 0;
        c[15] = pd > 27648;
        return c & en;
    endfunction : exp_diag

    function automatic logic signed [15:0] exp_avg(int q[$], int w);
        int n;
        int sum;
        n = (w == 0) ? 1 : ((q.size() < w) ? q.size() : w);
        sum = 0;
        for (int j = q.size() - n; j < q.size(); j++) begin
            sum += q[j];
        end
        return 16'(sum / n);
    endfunction : exp_avg

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic op(input logic wr, input logic [7:0] idx, input logic [15:0] d);
        m.xfer(wr, idx, d, rd, er, ok);
        if (ok !== 1'b1) begin
            fail_count++;
            report_and_stop();
        end
    endtask : op

    initial begin
        logic [15:0] en;
        logic [7:0] f;
        int pd;
        int q[$];
        int n;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            op(1'b0, 8'h40 + 8'(i), 16'h0000);
            chk(rd, rst_val[i]);
            en = 16'(rnd() % 27649);
            op(1'b1, 8'h40 + 8'(i % 3), en);
            op(1'b0, 8'h40 + 8'(i % 3), 16'h0000);
            chk(rd, en);
        end
        op(1'b1, 8'h43, 16'd64);
        chk({er, avg_error_q}, 2'b00);
        op(1'b1, 8'h43, 16'd65);
        chk({er, avg_error_q}, 2'b11);
        op(1'b0, 8'h43, 16'h0000);
        chk(rd, 64);
        op(1'b1, 8'h44, 16'h0005);
        chk({er, func_error_q}, 2'b11);
        for (int i = 9; i >= 6; i--) begin
            op(1'b1, 8'h44, 16'(i));
            op(1'b0, 8'h44, 16'h0000);
            chk({er, func_error_q, rd}, i);
        end
        op(1'b1, 8'h41, -16'sd1000);
        op(1'b1, 8'h42, 16'sd1000);
        for (int i = 0; i < 24; i++) begin
            en = 16'(rnd());
            f = 8'h06 + 8'(i % 4);
            pd = (i < 8) ? bnd[i] : int'($signed(16'(rnd())));
            op(1'b1, 8'h44, {8'h00, f});
            op(1'b1, 8'h40, en);
            pins <= 7'(rnd());
            meas_word <= 16'(rnd());
            m.cycle(16'(pd));
            repeat (8) @(posedge clk_sys);
            chk(diag_active_q, exp_diag(f, en, pd));
            repeat (24) @(posedge clk_sys);
        end
        foreach (wins[k]) begin
            // Window write clears the history
            op(1'b1, 8'h43, 16'(wins[k]));
            q = {};
            for (int j = 0; j < 5; j++) begin
                pd = int'($signed(16'(rnd())));
                q.push_back(pd);
                m.cycle(16'(pd));
                for (n = 0; n < 40 && filtered_valid_q !== 1'b1; n++) begin
                    @(posedge clk_sys);
                end
                if (n == 40) begin
                    fail_count++;
                    report_and_stop();
                end
                chk(filtered_word_q, exp_avg(q, wins[k]));
                repeat (6) @(posedge clk_sys);
            end
        end
        report_and_stop();
    end
endmodule : acpm_top_tb
`default_nettype wire
